// ===== gpc_params.svh
// Purpose: Register offsets, reset values and field widths of the GPIO port block.
// Assumes: APB word registers, one aligned 32-bit word each.
// Notes:   Included by the port top module; definitions only.
//
// Functional notes
// - Each port has per-pin readback, latch, direction, analog select, pull-up, threshold, slew and open-drain bits.
// - A pin handed to a peripheral is no longer driven from the latch, yet its level is still readable.
// - Writing the latch register updates the latch exactly as writing the readback register does.
// - Reading the latch returns the stored value; reading the readback register returns the sampled pin levels.
// - An analog-select bit turns off that pin's digital input path.
// - After reset every pin's output source is the data latch.
// - Peripheral outputs reach a pin only through the peripheral pin-select choice.
// - Analog input functions of a pin are enabled only while its analog-select bit is set.
// - Analog mode does not stop the selected digital source from driving the pin.
// - An enabled analog output overrides all digital sources and turns the digital driver off.
// - Direction 1 makes the pin an input with the driver off; direction 0 drives the pin.
// - A pin in analog mode always reads back as zero.
// - Analog-select bits reset to analog mode.
// - With open-drain set the pin only sinks and never drives high; clear, it drives both levels.
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

// Register byte offsets
`define GPC_OFF_READBACK   12'h000
`define GPC_OFF_LATCH      12'h004
`define GPC_OFF_DIRECTION  12'h008
`define GPC_OFF_ANALOG     12'h00C
`define GPC_OFF_PULLUP     12'h010
`define GPC_OFF_THRESHOLD  12'h014
`define GPC_OFF_SLEW       12'h018
`define GPC_OFF_OPENDRAIN  12'h01C
`define GPC_OFF_PINSEL     12'h020
`define GPC_OFF_AOUT       12'h024

// Per-bit reset values, replicated over the port width
`define GPC_RST_LATCH      1'b0
`define GPC_RST_DIRECTION  1'b1
`define GPC_RST_ANALOG     1'b1
`define GPC_RST_PULLUP     1'b0
`define GPC_RST_THRESHOLD  1'b0
`define GPC_RST_SLEW       1'b1
`define GPC_RST_OPENDRAIN  1'b0
`define GPC_RST_PINSEL     1'b0
`define GPC_RST_AOUT       1'b0

// Field width of one pin's source select
`define GPC_SEL_W          2

`endif

// ===== gpc_pkg.sv
// Purpose: Shared types of the GPIO port block.
// Assumes: Source select field is two bits wide.
// Notes:   Code 0 is the data latch; codes 1..3 are peripheral channels.
package gpc_pkg;

    // Output source of one pin
    typedef enum logic [1:0] {
        GPC_SRC_LATCH,
        GPC_SRC_PERIPH0,
        GPC_SRC_PERIPH1,
        GPC_SRC_PERIPH2
    } gpc_src_t;

    // APB answer kind, kept for the read/write decode
    typedef enum logic [0:0] {
        GPC_RESP_OKAY,
        GPC_RESP_ERROR
    } gpc_resp_t;

endpackage

// ===== gpc_pin_cell.sv
// Purpose: One pin: input synchroniser, output source mux and driver control.
// Assumes: Pad input is asynchronous to pclk.
// Notes:   Every output is a flip-flop; pad_oe_n is low while the pin is driven.
`timescale 1ns/1ps
module gpc_pin_cell #(
    parameter int SEL_W = 2,
    parameter int NPER  = 3
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             pad_in,
    input  wire logic             latch_bit,
    input  wire logic [NPER-1:0]  periph_bits,
    input  wire logic [SEL_W-1:0] src_sel,
    input  wire logic             dir,
    input  wire logic             ansel,
    input  wire logic             od,
    input  wire logic             aout_en,
    output logic                  pad_out,
    output logic                  pad_oe_n,
    output logic                  level
);

    logic              sync_a;
    logic              sync_b;
    logic [NPER:0]     sources;
    logic              src_bit;
    logic              drive;
    logic              next_out;
    logic              next_oe_n;

    // Two-stage synchroniser; only sync_b is read beyond here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= pad_in;
            sync_b <= sync_a;
        end
    end

    // Readback forced low in analog mode; input buffer is off there
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
        end else begin
            level <= sync_b & ~ansel;
        end
    end

    // Source mux: latch at code 0, peripherals above it
    assign sources = {periph_bits, latch_bit};
    assign src_bit = sources[src_sel];

    // Analog output and direction gate the driver; analog input mode does not
    assign drive = ~dir & ~aout_en;

    // Open drain never drives high: a one releases the pin instead
    always_comb begin
        next_out  = od ? 1'b0 : src_bit;
        next_oe_n = ~(drive & ~(od & src_bit));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out  <= 1'b0;
            pad_oe_n <= 1'b1;
        end else begin
            pad_out  <= next_out;
            pad_oe_n <= next_oe_n;
        end
    end

endmodule

// ===== gpc_port.sv
// Purpose: GPIO port with per-pin control registers behind an APB slave.
// Assumes: WIDTH up to 32, WIDTH*SEL_W up to 32; pads and peripherals outside.
// Notes:   Zero-wait reads are captured in setup; every access takes two cycles.
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_port #(
    parameter int WIDTH  = 8,
    parameter int ADDR_W = 12,
    parameter int SEL_W  = `GPC_SEL_W,
    parameter int NPER   = (1 << SEL_W) - 1
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [WIDTH-1:0]        pad_in,
    output logic      [WIDTH-1:0]        pad_out,
    output logic      [WIDTH-1:0]        pad_oe_n,
    output logic      [WIDTH-1:0]        pad_pullup_en,
    output logic      [WIDTH-1:0]        pad_threshold_sel,
    output logic      [WIDTH-1:0]        pad_slew_limit,
    output logic      [WIDTH-1:0]        pad_analog_in_en,
    output logic      [WIDTH-1:0]        pad_analog_out_en,
    input  wire logic [WIDTH*NPER-1:0]   periph_out,
    output logic      [WIDTH-1:0]        periph_in
);

    // Control registers
    logic [WIDTH-1:0]       output_latch;
    logic [WIDTH-1:0]       pin_direction;
    logic [WIDTH-1:0]       analog_select;
    logic [WIDTH-1:0]       weak_pullup_enable;
    logic [WIDTH-1:0]       input_threshold_select;
    logic [WIDTH-1:0]       slew_limit_enable;
    logic [WIDTH-1:0]       open_drain_enable;
    logic [WIDTH*SEL_W-1:0] peripheral_pin_select;
    logic [WIDTH-1:0]       analog_output_enable;

    // Sampled pin levels from the pin cells
    logic [WIDTH-1:0]       pin_level_readback;

    // Bus decode
    logic                   sel_readback;
    logic                   sel_latch;
    logic                   sel_direction;
    logic                   sel_analog;
    logic                   sel_pullup;
    logic                   sel_threshold;
    logic                   sel_slew;
    logic                   sel_opendrain;
    logic                   sel_pinsel;
    logic                   sel_aout;
    logic                   addr_hit;
    logic                   setup_phase;
    logic                   commit;
    logic                   wr_ok;
    logic [31:0]            next_rdata;
    gpc_pkg::gpc_resp_t     next_resp;

    // Address decode; misaligned addresses fall through to unmapped
    always_comb begin
        sel_readback  = (paddr == ADDR_W'(`GPC_OFF_READBACK));
        sel_latch     = (paddr == ADDR_W'(`GPC_OFF_LATCH));
        sel_direction = (paddr == ADDR_W'(`GPC_OFF_DIRECTION));
        sel_analog    = (paddr == ADDR_W'(`GPC_OFF_ANALOG));
        sel_pullup    = (paddr == ADDR_W'(`GPC_OFF_PULLUP));
        sel_threshold = (paddr == ADDR_W'(`GPC_OFF_THRESHOLD));
        sel_slew      = (paddr == ADDR_W'(`GPC_OFF_SLEW));
        sel_opendrain = (paddr == ADDR_W'(`GPC_OFF_OPENDRAIN));
        sel_pinsel    = (paddr == ADDR_W'(`GPC_OFF_PINSEL));
        sel_aout      = (paddr == ADDR_W'(`GPC_OFF_AOUT));
        addr_hit      = sel_readback | sel_latch | sel_direction | sel_analog
                      | sel_pullup | sel_threshold | sel_slew | sel_opendrain
                      | sel_pinsel | sel_aout;
    end

    // Setup is the first cycle; the access edge commits the transfer
    assign setup_phase = psel & ~penable;
    assign commit      = psel & penable & pready;
    assign wr_ok       = commit & pwrite & addr_hit;

    // Read data mux; unused upper bits read as zero
    always_comb begin
        next_rdata = '0;
        next_resp  = addr_hit ? gpc_pkg::GPC_RESP_OKAY : gpc_pkg::GPC_RESP_ERROR;
        if (sel_readback) begin
            next_rdata[WIDTH-1:0] = pin_level_readback;
        end else if (sel_latch) begin
            next_rdata[WIDTH-1:0] = output_latch;
        end else if (sel_direction) begin
            next_rdata[WIDTH-1:0] = pin_direction;
        end else if (sel_analog) begin
            next_rdata[WIDTH-1:0] = analog_select;
        end else if (sel_pullup) begin
            next_rdata[WIDTH-1:0] = weak_pullup_enable;
        end else if (sel_threshold) begin
            next_rdata[WIDTH-1:0] = input_threshold_select;
        end else if (sel_slew) begin
            next_rdata[WIDTH-1:0] = slew_limit_enable;
        end else if (sel_opendrain) begin
            next_rdata[WIDTH-1:0] = open_drain_enable;
        end else if (sel_pinsel) begin
            next_rdata[WIDTH*SEL_W-1:0] = peripheral_pin_select;
        end else if (sel_aout) begin
            next_rdata[WIDTH-1:0] = analog_output_enable;
        end
    end

    // Answer registered in setup so the access phase needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase & (next_resp == gpc_pkg::GPC_RESP_ERROR);
            if (setup_phase && !pwrite) begin
                prdata <= next_rdata;
            end else if (commit) begin
                prdata <= '0;
            end
        end
    end

    // Latch: both the readback and latch offsets write it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_latch <= {WIDTH{`GPC_RST_LATCH}};
        end else if (wr_ok && (sel_readback || sel_latch)) begin
            output_latch <= pwdata[WIDTH-1:0];
        end
    end

    // Direction: one is input, driver off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction <= {WIDTH{`GPC_RST_DIRECTION}};
        end else if (wr_ok && sel_direction) begin
            pin_direction <= pwdata[WIDTH-1:0];
        end
    end

    // Analog select starts in analog mode; software clears for digital use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_select <= {WIDTH{`GPC_RST_ANALOG}};
        end else if (wr_ok && sel_analog) begin
            analog_select <= pwdata[WIDTH-1:0];
        end
    end

    // Pull-ups touch nothing but the pad pull-up control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            weak_pullup_enable <= {WIDTH{`GPC_RST_PULLUP}};
        end else if (wr_ok && sel_pullup) begin
            weak_pullup_enable <= pwdata[WIDTH-1:0];
        end
    end

    // Threshold select; change only with peripherals idle to avoid glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_threshold_select <= {WIDTH{`GPC_RST_THRESHOLD}};
        end else if (wr_ok && sel_threshold) begin
            input_threshold_select <= pwdata[WIDTH-1:0];
        end
    end

    // Slew limiting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slew_limit_enable <= {WIDTH{`GPC_RST_SLEW}};
        end else if (wr_ok && sel_slew) begin
            slew_limit_enable <= pwdata[WIDTH-1:0];
        end
    end

    // Open-drain selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_drain_enable <= {WIDTH{`GPC_RST_OPENDRAIN}};
        end else if (wr_ok && sel_opendrain) begin
            open_drain_enable <= pwdata[WIDTH-1:0];
        end
    end

    // Source select per pin; reset hands every pin to the latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_pin_select <= {(WIDTH*SEL_W){`GPC_RST_PINSEL}};
        end else if (wr_ok && sel_pinsel) begin
            peripheral_pin_select <= pwdata[WIDTH*SEL_W-1:0];
        end
    end

    // Analog output enables, e.g. a DAC routed to the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_output_enable <= {WIDTH{`GPC_RST_AOUT}};
        end else if (wr_ok && sel_aout) begin
            analog_output_enable <= pwdata[WIDTH-1:0];
        end
    end

    // Pad controls come straight from their registers
    assign pad_pullup_en     = weak_pullup_enable;
    assign pad_threshold_sel = input_threshold_select;
    assign pad_slew_limit    = slew_limit_enable;
    assign pad_analog_in_en  = analog_select;
    assign pad_analog_out_en = analog_output_enable;

    // Peripherals see the same gated level as software does
    assign periph_in = pin_level_readback;

    // One cell per pin
    for (genvar p = 0; p < WIDTH; p++) begin : g_pin
        gpc_pin_cell #(
            .SEL_W (SEL_W),
            .NPER  (NPER)
        ) u_cell (
            .pclk        (pclk),
            .presetn     (presetn),
            .pad_in      (pad_in[p]),
            .latch_bit   (output_latch[p]),
            .periph_bits (periph_out[p*NPER +: NPER]),
            .src_sel     (peripheral_pin_select[p*SEL_W +: SEL_W]),
            .dir         (pin_direction[p]),
            .ansel       (analog_select[p]),
            .od          (open_drain_enable[p]),
            .aout_en     (analog_output_enable[p]),
            .pad_out     (pad_out[p]),
            .pad_oe_n    (pad_oe_n[p]),
            .level       (pin_level_readback[p])
        );
    end

endmodule

// ===== gpc_pad_model.sv
// Purpose: Pins and far-side drivers of the GPIO port.
// Assumes: One external driver per pin, enabled per bit.
// Notes:   An undriven pin without pull-up wanders every cycle.
`timescale 1ns/1ps
module gpc_pad_model #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic [WIDTH-1:0] pad_out,
    input  wire logic [WIDTH-1:0] pad_oe_n,
    input  wire logic [WIDTH-1:0] pad_pullup_en,
    input  wire logic [WIDTH-1:0] ext_en,
    input  wire logic [WIDTH-1:0] ext_val,
    output logic      [WIDTH-1:0] pad_level
);
    logic [WIDTH-1:0] flt = '0;
    // Floating level changes so no stale value passes
    always @(posedge pclk) begin
        flt <= ~flt;
    end
    // Wire level: port driver, else far side, else pull-up
    assign pad_level = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
                     | (pad_oe_n & ~ext_en & (pad_pullup_en | flt));
endmodule

// ===== gpc_port_properties.sv
// Purpose: Port-level properties of the GPIO port.
// Assumes: Single clock domain, reset active low.
// Notes:   Sees only top-level ports; bound below.
`timescale 1ns/1ps
module gpc_port_properties #(
    parameter int WIDTH = 8
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [31:0]      prdata,
    input wire logic [WIDTH-1:0] pad_out,
    input wire logic [WIDTH-1:0] pad_oe_n,
    input wire logic [WIDTH-1:0] pad_pullup_en,
    input wire logic [WIDTH-1:0] pad_slew_limit,
    input wire logic [WIDTH-1:0] pad_analog_in_en,
    input wire logic [WIDTH-1:0] pad_analog_out_en,
    input wire logic [WIDTH-1:0] periph_in
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus timing and answer
    property p_setup_ready; psel && !penable |=> pready; endproperty
    a_setup_ready: assert property (p_setup_ready)
        else $error("No ready after setup");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("Ready held too long");
    property p_ready_cause; pready |-> $past(psel && !penable); endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("Ready without setup");
    property p_err_with_ready; pslverr |-> pready; endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("Error without ready");
    property p_rdata_upper; pready && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
    a_rdata_upper: assert property (p_rdata_upper)
        else $error("Read data upper bits set");
    // Pin side: driver release and input gating lag one flop
    property p_aout_release; (~pad_oe_n & $past(pad_analog_out_en)) == '0; endproperty
    a_aout_release: assert property (p_aout_release)
        else $error("Driver on under analog output");
    property p_analog_zero; (periph_in & $past(pad_analog_in_en)) == '0; endproperty
    a_analog_zero: assert property (p_analog_zero)
        else $error("Analog pin reads nonzero");
    property p_reset_pins;
        $rose(presetn) |-> (&pad_oe_n) && pad_out == '0 && (&pad_analog_in_en);
    endproperty
    a_reset_pins: assert property (p_reset_pins)
        else $error("Pins not at reset state");
    property p_cfg_stable;
        !(psel && penable && pready && pwrite) |=> $stable(pad_pullup_en)
            && $stable(pad_slew_limit);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable)
        else $error("Config moved without write");
endmodule
bind gpc_port gpc_port_properties #(.WIDTH(WIDTH)) u_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .pready, .pslverr, .prdata, .pad_out, .pad_oe_n, .pad_pullup_en,
    .pad_slew_limit, .pad_analog_in_en, .pad_analog_out_en, .periph_in);

// ===== tb_gpio_port_pin_control.sv
// Purpose: Register and pin tests of the GPIO port.
// Assumes: Zero-wait APB slave, pins modelled by the pad model.
// Notes:   Pin changes are read after a settle of five edges.
`timescale 1ns/1ps
`include "gpc_params.svh"
module tb_gpio_port_pin_control;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic        pready, pslverr;
    logic [7:0]  pad_in, pad_out, pad_oe_n, pu, thr, slw, ain, aout, pin;
    logic [7:0]  ext_en = 8'hFF, ext_val = 8'h96;
    logic [23:0] periph_out = '0;
    logic [7:0]  rst_v [10] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF,
                                8'h00, 8'h00, 8'h00};
    int          fails = 0, tests_run = 0, cyc = 0;
    gpc_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pad_in, .pad_out, .pad_oe_n, .pad_pullup_en(pu),
        .pad_threshold_sel(thr), .pad_slew_limit(slw), .pad_analog_in_en(ain),
        .pad_analog_out_en(aout), .periph_out, .periph_in(pin));
    gpc_pad_model pads (.pclk, .pad_out, .pad_oe_n, .pad_pullup_en(pu), .ext_en,
        .ext_val, .pad_level(pad_in));
    // Clock and hang guard
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    task complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // One APB transfer; request held until ready is sampled
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
    task rd(input logic [11:0] a, input logic [31:0] e); xfer(1'b0, a, '0); chk(rdat, e);
    endtask
    task settle(); repeat (5) @(posedge pclk); endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) rd(12'(i * 4), 32'(rst_v[i]));
        wr(`GPC_OFF_ANALOG, 32'h00);
        wr(`GPC_OFF_DIRECTION, 32'h00);
        wr(`GPC_OFF_LATCH, 32'hA5);
        wr(`GPC_OFF_READBACK, 32'h3C);
        rd(`GPC_OFF_LATCH, 32'h3C);
        settle();
        chk(32'(pad_out), 32'h3C);
        chk(32'(pad_oe_n), 32'h00);
        rd(`GPC_OFF_READBACK, 32'h3C);
        wr(`GPC_OFF_DIRECTION, 32'hFF);
        settle();
        chk(32'(pad_oe_n), 32'hFF);
        rd(`GPC_OFF_READBACK, 32'h96);
        rd(`GPC_OFF_LATCH, 32'h3C);
        wr(`GPC_OFF_ANALOG, 32'hF0);
        settle();
        rd(`GPC_OFF_READBACK, 32'h06);
        chk(32'(pin), 32'h06);
        chk(32'(ain), 32'hF0);
        wr(`GPC_OFF_DIRECTION, 32'h00);
        settle();
        chk({pad_oe_n, pad_out}, 32'h003C);
        wr(`GPC_OFF_ANALOG, 32'h00);
        wr(`GPC_OFF_LATCH, 32'h00);
        // Each peripheral channel on pin 1, latch held low
        for (int c = 1; c < 4; c++) begin
            periph_out <= 24'h1 << (2 + c);
            wr(`GPC_OFF_PINSEL, 32'(c << 2));
            settle();
            chk(32'(pad_out), 32'h02);
            rd(`GPC_OFF_READBACK, 32'h02);
        end
        wr(`GPC_OFF_PINSEL, 32'h00);
        settle();
        chk(32'(pad_out), 32'h00);
        wr(`GPC_OFF_AOUT, 32'h01);
        settle();
        chk({aout, pad_oe_n}, 32'h0101);
        wr(`GPC_OFF_AOUT, 32'h00);
        wr(`GPC_OFF_OPENDRAIN, 32'hFF);
        wr(`GPC_OFF_LATCH, 32'h0F);
        settle();
        chk({pad_oe_n, pad_out}, 32'h0F00);
        wr(`GPC_OFF_OPENDRAIN, 32'h00);
        wr(`GPC_OFF_DIRECTION, 32'hFF);
        ext_en <= 8'hAA;
        ext_val <= 8'h00;
        wr(`GPC_OFF_PULLUP, 32'h55);
        settle();
        chk(32'(pu), 32'h55);
        rd(`GPC_OFF_READBACK, 32'h55);
        rd(`GPC_OFF_DIRECTION, 32'hFF);
        rd(`GPC_OFF_LATCH, 32'h0F);
        wr(`GPC_OFF_THRESHOLD, 32'h5A);
        wr(`GPC_OFF_SLEW, 32'h00);
        // The write lands at the edge the task returns on; look one edge later
        @(posedge pclk);
        chk({thr, slw}, 32'h5A00);
        xfer(1'b1, 12'h028, 32'hFF);
        chk(32'(rerr), 32'h1);
        xfer(1'b0, 12'h002, '0);
        chk({rdat[30:0], rerr}, 32'h1);
        wr(`GPC_OFF_PINSEL, 32'h04);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd(`GPC_OFF_PINSEL, 32'h00);
        rd(`GPC_OFF_ANALOG, 32'hFF);
        complete_run();
    end
endmodule
